// file: verilog/sacs_regs.vh
// How it works
// RL1 - Resolution selectable as 8, 10 or 12 bits.
// RL2 - Discharge all capacitors before sampling.
// RL3 - Acquire input, then switch all to ground.
// RL4 - MSB trial: top capacitor to reference.
// RL5 - Keep capacitor on bit one, else ground.
// RL6 - Repeat trials down to the last bit.
// RL7 - Conversion takes acquisition plus N+1 cycles.
// RL8 - Requests spaced to stay under 600 ksps.
// RL9 - Calibrate at power-up and after samples.
// RL10 - Code steps equal reference over two-to-n.
// RL11 - Pad is digital only while enable high.
// RL12 - Digital pad level shown on its output.
// RL13 - Latch result and pulse done once.
// RL14 - Ignore requests while busy; report busy.
`ifndef SACS_REGS_VH
`define SACS_REGS_VH
`define SACS_CLK_HZ 50000000
`define SACS_MAX_SPS 600000
`define SACS_MIN_GAP ((`SACS_CLK_HZ + `SACS_MAX_SPS - 1) / `SACS_MAX_SPS)
`define SACS_DISCH_CYC 4'h2
`define SACS_ACQ_CYC 8'h10
`define SACS_CAL_PWRUP_CYC 8'h20
`define SACS_CAL_DYN_CYC 8'h02
`define SACS_RES_8 2'h0
`define SACS_RES_10 2'h1
`define SACS_RES_12 2'h2
`define SACS_NBITS 12
`define SACS_NPADS 10
`define SACS_FIFO_DEPTH 16
`endif

// file: verilog/sacs_fifo.v
`timescale 1ns/1ps
`default_nettype none
module sacs_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire mclk, // Clock.
  input wire rst_n, // Synchronous reset, active low.
  input wire [WIDTH-1:0] in_data, // Write data.
  input wire in_valid, // Write request.
  output wire in_ready, // Not full.
  output wire [WIDTH-1:0] out_data, // Head word.
  output wire out_valid, // Not empty.
  input wire out_ready // Reader takes head.
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  wire wr = in_valid && in_ready;
  wire rd = out_valid && out_ready;
  assign in_ready = (wp_q - rp_q) != DEPTH[AW:0];
  assign out_valid = wp_q != rp_q;
  assign out_data = mem[rp_q[AW-1:0]];
  always @(posedge mclk) begin
    if (wr) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
    if (!rst_n) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (wr) begin
        wp_q <= wp_q + 1'b1;
      end
      if (rd) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule // sacs_fifo
`default_nettype wire

// file: verilog/sacs_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "sacs_regs.vh"
module sacs_sequencer (
  input wire mclk, // 50 MHz converter clock.
  input wire rst_n, // Synchronous reset, active low.
  input wire start, // Conversion request, one cycle.
  input wire [1:0] res_sel, // 0: 8 bits, 1: 10 bits, 2: 12 bits.
  input wire comp_out, // Comparator, high when input above trial.
  input wire [`SACS_NPADS-1:0] pad_digital_input_enable, // Per quad enable.
  input wire [`SACS_NPADS-1:0] voltage_monitor_pad, // Pad levels.
  input wire [`SACS_NPADS-1:0] current_monitor_pad, // Pad levels.
  input wire [`SACS_NPADS-1:0] temperature_monitor_pad, // Pad levels.
  input wire res_ready, // Fabric takes a result.
  output reg cap_discharge, // Discharge all array capacitors.
  output reg cap_sample, // Input to all capacitors.
  output reg [`SACS_NBITS-1:0] cap_to_ref, // Capacitor to reference, else ground.
  output reg cal_active, // Calibration running.
  output reg busy, // Conversion or calibration in progress.
  output reg done, // Result latched, one cycle.
  output reg [`SACS_NBITS-1:0] result, // Last result, right aligned.
  output reg [`SACS_NBITS-1:0] res_data, // FIFO head.
  output reg res_valid, // FIFO head valid.
  output reg [`SACS_NPADS-1:0] pad_digital_level_out_v, // Voltage pad levels.
  output reg [`SACS_NPADS-1:0] pad_digital_level_out_c, // Current pad levels.
  output reg [`SACS_NPADS-1:0] pad_digital_level_out_t // Temperature pad levels.
);
  // ---------------------------------------------------------------
  // Constants and helpers
  // ---------------------------------------------------------------
  localparam S_CAL = 3'h0;
  localparam S_IDLE = 3'h1;
  localparam S_DISCH = 3'h2;
  localparam S_ACQ = 3'h3;
  localparam S_HOLD = 3'h4;
  localparam S_TRIAL = 3'h5;
  localparam S_DONE = 3'h6;
  localparam S_DCAL = 3'h7;
  // The spacing count is worked out as a 32-bit integer; only 16 bits are kept.
  localparam [31:0] MIN_GAP_W = `SACS_MIN_GAP;
  localparam [15:0] MIN_GAP = MIN_GAP_W[15:0];

  // One-hot capacitor select: bit k is the capacitor of weight 2^k.
  function [`SACS_NBITS-1:0] onehot;
    input [3:0] k;
    begin
      onehot = {{(`SACS_NBITS-1){1'b0}}, 1'b1} << k;
    end
  endfunction

  // Filtered pad level: enabled pads take agreed levels and hold otherwise.
  function [`SACS_NPADS-1:0] pad_next;
    input [`SACS_NPADS-1:0] en;
    input [`SACS_NPADS-1:0] ok;
    input [`SACS_NPADS-1:0] lvl;
    input [`SACS_NPADS-1:0] held;
    begin
      pad_next = en & ((ok & lvl) | (~ok & held));
    end
  endfunction

  // Reserved selection code falls back to full width.
  function [3:0] nbits;
    input [1:0] sel;
    begin
      case (sel)
        `SACS_RES_8: nbits = 4'h8;
        `SACS_RES_10: nbits = 4'ha;
        default: nbits = 4'hc;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  reg [2:0] st_q;
  reg [7:0] cnt_q;
  reg [3:0] bit_q;
  reg [3:0] nb_q;
  reg [15:0] gap_q;
  reg [`SACS_NBITS-1:0] sar_q;
  reg push_q;
  wire fifo_in_ready;
  wire [`SACS_NBITS-1:0] fifo_out_data;
  wire fifo_out_valid;
  // Besides the spacing count, the start gate blocks starts while the FIFO is full, so no
  // result is ever dropped; the fabric stalls conversions by not reading.
  wire can_start = (gap_q == 16'h0) && fifo_in_ready; // RL8
  // Trial value: bits decided so far plus the bit under test.
  wire [`SACS_NBITS-1:0] trial = sar_q | onehot(bit_q);

  always @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= S_CAL;
      cnt_q <= `SACS_CAL_PWRUP_CYC;
      bit_q <= 4'h0;
      nb_q <= 4'hc;
      gap_q <= 16'h0;
      sar_q <= {`SACS_NBITS{1'b0}};
      push_q <= 1'b0;
      cap_discharge <= 1'b0;
      cap_sample <= 1'b0;
      cap_to_ref <= {`SACS_NBITS{1'b0}};
      cal_active <= 1'b1;
      busy <= 1'b1;
      done <= 1'b0;
      result <= {`SACS_NBITS{1'b0}};
    end else begin
      done <= 1'b0;
      push_q <= 1'b0;
      if (gap_q != 16'h0) begin
        gap_q <= gap_q - 16'h1;
      end
      case (st_q)
        S_CAL: begin
          cal_active <= 1'b1; // RL9
          if (cnt_q == 8'h0) begin
            cal_active <= 1'b0;
            busy <= 1'b0;
            st_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h1;
          end
        end
        S_IDLE: begin
          // Requests while busy never reach this state, so they are dropped.
          if (start && can_start) begin // RL14
            busy <= 1'b1;
            gap_q <= MIN_GAP - 16'h1; // RL8
            nb_q <= nbits(res_sel); // RL1
            sar_q <= {`SACS_NBITS{1'b0}};
            cap_to_ref <= {`SACS_NBITS{1'b0}};
            cap_discharge <= 1'b1; // RL2
            cnt_q <= {4'h0, `SACS_DISCH_CYC} - 8'h1;
            st_q <= S_DISCH;
          end
        end
        S_DISCH: begin
          if (cnt_q == 8'h0) begin
            cap_discharge <= 1'b0;
            cap_sample <= 1'b1; // RL3
            cnt_q <= `SACS_ACQ_CYC - 8'h1;
            st_q <= S_ACQ;
          end else begin
            cnt_q <= cnt_q - 8'h1;
          end
        end
        S_ACQ: begin
          if (cnt_q == 8'h0) begin
            // All capacitors to ground: the negated input faces the comparator.
            cap_sample <= 1'b0; // RL3
            st_q <= S_HOLD;
          end else begin
            cnt_q <= cnt_q - 8'h1;
          end
        end
        S_HOLD: begin
          // Top capacitor of the selected width goes to reference first.
          bit_q <= nb_q - 4'h1; // RL4
          cap_to_ref <= onehot(nb_q - 4'h1); // RL4
          st_q <= S_TRIAL;
        end
        S_TRIAL: begin
          // The hold cycle plus N trials give N+1 cycles after acquisition.
          if (comp_out) begin // RL5
            sar_q <= trial;
          end
          if (bit_q == 4'h0) begin // RL6
            st_q <= S_DONE;
            cap_to_ref <= comp_out ? trial : sar_q; // RL7
          end else begin
            bit_q <= bit_q - 4'h1; // RL6
            cap_to_ref <= (comp_out ? trial : sar_q) | onehot(bit_q - 4'h1); // RL5
          end
        end
        S_DONE: begin
          // Code is LSB-weighted: one step equals reference over 2^n.
          result <= sar_q; // RL10
          done <= 1'b1; // RL13
          push_q <= 1'b1;
          cap_to_ref <= {`SACS_NBITS{1'b0}};
          cal_active <= 1'b1; // RL9
          cnt_q <= `SACS_CAL_DYN_CYC - 8'h1;
          st_q <= S_DCAL;
        end
        S_DCAL: begin
          if (cnt_q == 8'h0) begin
            cal_active <= 1'b0;
            busy <= 1'b0; // RL14
            st_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h1;
          end
        end
        default: begin
          st_q <= S_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Result buffer
  // ---------------------------------------------------------------
  sacs_fifo #(
    .WIDTH(`SACS_NBITS),
    .DEPTH(`SACS_FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_data(result),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(res_ready && res_valid)
  );

  // Registered view of the head; one cycle behind after each pop.
  always @(posedge mclk) begin
    if (!rst_n) begin
      res_data <= {`SACS_NBITS{1'b0}};
      res_valid <= 1'b0;
    end else begin
      res_data <= fifo_out_data;
      res_valid <= fifo_out_valid && !(res_ready && res_valid);
    end
  end

  // ---------------------------------------------------------------
  // Direct digital pad inputs
  // ---------------------------------------------------------------
  // Three stages; a level counts once the last two agree. Pads toggle
  // at 10 MHz at most, so the 50 MHz sampling keeps every edge.
  reg [3*`SACS_NPADS-1:0] p1_q;
  reg [3*`SACS_NPADS-1:0] p2_q;
  reg [3*`SACS_NPADS-1:0] p3_q;
  wire [3*`SACS_NPADS-1:0] pads = {temperature_monitor_pad, current_monitor_pad,
                                   voltage_monitor_pad};
  wire [3*`SACS_NPADS-1:0] agree = ~(p2_q ^ p3_q);
  wire [3*`SACS_NPADS-1:0] en3 = {3{pad_digital_input_enable}};
  always @(posedge mclk) begin
    if (!rst_n) begin
      p1_q <= {(3*`SACS_NPADS){1'b0}};
      p2_q <= {(3*`SACS_NPADS){1'b0}};
      p3_q <= {(3*`SACS_NPADS){1'b0}};
      pad_digital_level_out_v <= {`SACS_NPADS{1'b0}};
      pad_digital_level_out_c <= {`SACS_NPADS{1'b0}};
      pad_digital_level_out_t <= {`SACS_NPADS{1'b0}};
    end else begin
      p1_q <= pads;
      p2_q <= p1_q;
      p3_q <= p2_q;
      // Disabled pads read low; agreed levels update, others hold.
      pad_digital_level_out_v <= pad_next(en3[9:0], agree[9:0], p3_q[9:0],
                                          pad_digital_level_out_v); // RL11
      pad_digital_level_out_c <= pad_next(en3[19:10], agree[19:10], p3_q[19:10],
                                          pad_digital_level_out_c); // RL12
      pad_digital_level_out_t <= pad_next(en3[29:20], agree[29:20], p3_q[29:20],
                                          pad_digital_level_out_t); // RL12
    end
  end
endmodule // sacs_sequencer
`default_nettype wire

// file: dv/sacs_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "sacs_regs.vh"
module sacs_sequencer_sva (
  input wire logic mclk, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic start, // Request.
  input wire logic busy, // Busy.
  input wire logic done, // Done pulse.
  input wire logic cal_active, // Calibration.
  input wire logic cap_discharge, // Discharge.
  input wire logic cap_sample, // Acquire.
  input wire logic [`SACS_NBITS-1:0] cap_to_ref, // Array switches.
  input wire logic [`SACS_NBITS-1:0] result, // Result.
  input wire logic [`SACS_NPADS-1:0] pad_digital_input_enable, // Pad enables.
  input wire logic [`SACS_NPADS-1:0] pad_digital_level_out_v // Pad levels.
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [7:0] gap_q;
  logic [`SACS_NPADS-1:0] en_1_q;
  // Saturates so an idle spell never wraps into a false short gap.
  always @(posedge mclk) begin
    en_1_q <= pad_digital_input_enable;
    if (!rst_n) gap_q <= 8'hff;
    else if ($rose(cap_discharge)) gap_q <= 8'h01;
    else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
  end
  sequence s_acq;
    cap_sample[*8] ##1 cap_sample[*8] ##1 !cap_sample;
  endsequence
  a_disch_two: assert property ($rose(cap_discharge) |-> cap_discharge ##1 cap_discharge
    ##1 (!cap_discharge && cap_sample)) else $error("discharge phase wrong");
  a_acq_ground: assert property ($rose(cap_sample) |-> s_acq ##0 cap_to_ref == 12'h000)
    else $error("acquisition phase wrong");
  a_msb_first: assert property ($fell(cap_sample) |=> cap_to_ref inside {12'h080, 12'h200,
    12'h800}) else $error("first trial not top capacitor");
  a_conv_len: assert property ($rose(cap_discharge) |-> ##[28:32] done)
    else $error("conversion length wrong");
  a_take_idle: assert property ($rose(cap_discharge) |-> $past(start) && !$past(busy))
    else $error("conversion began while busy");
  a_rate_gap: assert property ($rose(cap_discharge) |-> gap_q >= 8'h54)
    else $error("conversions too close");
  a_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
  a_result_hold: assert property (!done |-> $stable(result)) else $error("result moved");
  a_busy_end: assert property (done |-> busy ##1 busy ##1 !busy)
    else $error("busy end wrong");
  a_dyn_cal: assert property (done |-> cal_active ##1 cal_active ##1 !cal_active)
    else $error("dynamic calibration window wrong");
  a_pad_gate: assert property ((pad_digital_level_out_v & ~en_1_q) == 10'h000)
    else $error("pad level shown while disabled");
endmodule // sacs_sequencer_sva
bind sacs_sequencer sacs_sequencer_sva u_sva (.mclk, .rst_n, .start, .busy, .done,
  .cal_active, .cap_discharge, .cap_sample, .cap_to_ref, .result, .pad_digital_input_enable,
  .pad_digital_level_out_v);
`default_nettype wire

// file: dv/sacs_array_model.sv
`timescale 1ns/1ps
`default_nettype none
module sacs_array_model (
  input wire logic [11:0] cap_to_ref, // Capacitors on reference.
  input wire logic [1:0] res_sel, // Resolution.
  input wire logic [11:0] vin, // Input as a fraction of full scale.
  output logic comp_out // Comparator.
);
  logic [3:0] drop;
  assign drop = (res_sel == 2'h0) ? 4'h4 : (res_sel == 2'h1) ? 4'h2 : 4'h0;
  // High when the input reaches the trial level in steps of reference over 2^n.
  assign comp_out = (vin >> drop) >= cap_to_ref;
endmodule // sacs_array_model
`default_nettype wire

// file: dv/sacs_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sacs_sequencer_bench;
  logic mclk, rst_n, start, comp_out, res_ready, busy, done, cal_active;
  logic cap_discharge, cap_sample, res_valid;
  logic [1:0] res_sel;
  logic [11:0] vin, cap_to_ref, result, res_data;
  logic [9:0] en, pv, pc, pt, ov, oc, ot;
  logic [11:0] exp_q[$];
  int error_cnt = 0;
  int checks_done = 0;
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  sacs_sequencer dut (.mclk, .rst_n, .start, .res_sel, .comp_out, .pad_digital_input_enable(en),
    .voltage_monitor_pad(pv), .current_monitor_pad(pc), .temperature_monitor_pad(pt),
    .res_ready, .cap_discharge, .cap_sample, .cap_to_ref, .cal_active, .busy, .done, .result,
    .res_data, .res_valid, .pad_digital_level_out_v(ov), .pad_digital_level_out_c(oc),
    .pad_digital_level_out_t(ot));
  sacs_array_model u_arr (.cap_to_ref, .res_sel, .vin, .comp_out);
  task chk(input string what, input logic [11:0] e, input logic [11:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Each call spans 90 cycles, so every real start keeps the 84-cycle spacing.
  task convert(input logic [1:0] sel, input logic [11:0] v);
    res_sel = sel;
    vin = v;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    exp_q.push_back(v >> ((sel == 2'h0) ? 4 : (sel == 2'h1) ? 2 : 0));
    repeat (9) @(negedge mclk);
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    repeat (34) @(negedge mclk);
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    repeat (44) @(negedge mclk);
  endtask
  always @(posedge mclk) begin
    if (rst_n && res_valid === 1'b1 && res_ready === 1'b1) begin
      if (exp_q.size() == 0) chk("results pending", 12'h000, 12'h001);
      else chk("res_data", exp_q.pop_front(), res_data);
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("FAIL run length expected end seen hang");
    wrap_up;
  end
  initial begin
    rst_n = 1'b0; start = 1'b0; res_sel = 2'h0; vin = 12'h000; res_ready = 1'b1;
    en = 10'h000; pv = 10'h000; pc = 10'h000; pt = 10'h000;
    void'($urandom(62));
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    chk("cal_active", 12'h001, {11'h000, cal_active});
    for (int i = 0; i < 60 && busy !== 1'b0; i++) @(negedge mclk);
    chk("busy", 12'h000, {11'h000, busy});
    $display("test power-up done");
    for (int s = 0; s < 4; s++) begin
      convert(2'(s), 12'h000);
      convert(2'(s), 12'hfff);
      convert(2'(s), 12'($urandom));
    end
    $display("test modes done");
    res_ready = 1'b0;
    repeat (16) convert(2'($urandom), 12'($urandom));
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) begin
      res_ready = 1'($urandom);
      @(negedge mclk);
    end
    chk("results left", 12'h000, 12'(exp_q.size()));
    $display("test buffer done");
    repeat (8) begin
      en = 10'($urandom); pv = 10'($urandom); pc = 10'($urandom); pt = 10'($urandom);
      repeat (6) @(negedge mclk);
      chk("pad_v", {2'h0, pv & en}, {2'h0, ov});
      chk("pad_c", {2'h0, pc & en}, {2'h0, oc});
      chk("pad_t", {2'h0, pt & en}, {2'h0, ot});
    end
    $display("test pads done");
    wrap_up;
  end
endmodule // sacs_sequencer_bench
`default_nettype wire
